// *** hw/ctrl_pin_pkg.sv ***
// shared constants and types for the control-mode pin decoder
package ctrl_pin_pkg;

    // three sensed states of a configuration pin
    typedef enum logic [1:0]
    {
        LVL_LOW   = 2'b00,
        LVL_FLOAT = 2'b01,
        LVL_HIGH  = 2'b11
    } level_t;

    // internal reset sequencer, gray along hold -> count -> run
    typedef enum logic [1:0]
    {
        RST_HOLD  = 2'b00,
        RST_COUNT = 2'b01,
        RST_RUN   = 2'b11
    } rst_state_t;

    // pin slots in the sensed vector
    localparam int unsigned PIN_COUNT = 4;
    localparam int unsigned PIN_OUTPUT_LEVEL_SELECT  = 0;
    localparam int unsigned PIN_EDGE  = 1;
    localparam int unsigned PIN_MODE  = 2;
    localparam int unsigned PIN_CAL   = 3;

    // consecutive identical samples before a pin level is accepted
    localparam logic [2:0] SENSE_STABLE_CYCLES = 3'h4;

    // internal reset length after the external reset releases
    localparam logic [4:0] RST_HOLD_CYCLES = 5'h10;

    // register byte offsets
    localparam logic [3:0] OFS_STATUS  = 4'h0;
    localparam logic [3:0] OFS_CTRL    = 4'h4;
    localparam logic [3:0] OFS_SWORD   = 4'h8;
    localparam logic [3:0] OFS_SCOUNT  = 4'hc;

    // status field positions
    localparam int unsigned ST_RUN      = 0;
    localparam int unsigned ST_SERIAL   = 1;
    localparam int unsigned ST_FSR      = 2;
    localparam int unsigned ST_OUTPUT_LEVEL_SELECT     = 3;
    localparam int unsigned ST_EDGE     = 4;
    localparam int unsigned ST_DDR      = 5;
    localparam int unsigned ST_CAL_LONG = 6;
    localparam int unsigned ST_SER_EN   = 7;
    localparam int unsigned ST_LVL_LSB  = 8;

    // control field positions and reset value
    localparam int unsigned CTRL_DATA_OUTPUT_CLOCK_EN = 0;
    localparam logic        CTRL_DATA_OUTPUT_CLOCK_EN_RST = 1'b1;

    // classify a pin from its upper and lower threshold comparators
    function automatic level_t classify(input logic above_hi, input logic below_lo);
        if (above_hi && !below_lo)
            return LVL_HIGH;
        else if (below_lo && !above_hi)
            return LVL_LOW;
        else
            return LVL_FLOAT;
    endfunction

endpackage

// *** hw/pin_levels_if.sv ***
// carrier for the filtered three-level pin states
`timescale 1ns/1ns
interface pin_levels_if;
    import ctrl_pin_pkg::*;
    level_t [PIN_COUNT-1:0] lvl;

    modport sense (output lvl);
    modport user  (input  lvl);
endinterface

// *** hw/tri_level_sense.sv ***
// three-level pin sensing with a stability filter
`timescale 1ns/1ns
module tri_level_sense
    import ctrl_pin_pkg::*;
(
    // clock and reset
    input  wire logic                 clk,
    input  wire logic                 nrst,
    // comparator outputs per pin
    input  wire logic [PIN_COUNT-1:0] above_hi,
    input  wire logic [PIN_COUNT-1:0] below_lo,
    // filtered levels
    pin_levels_if.sense               levels
);

    typedef struct packed
    {
        level_t [PIN_COUNT-1:0]           lvl;
        level_t [PIN_COUNT-1:0]           cand;
        logic   [PIN_COUNT-1:0][2:0]      cnt;
    } sense_state_t;

    sense_state_t st;
    sense_state_t next_st;

    always_comb
    begin
        level_t raw;
        raw = LVL_FLOAT;
        next_st = st;
        for (int i = 0; i < PIN_COUNT; i++)
        begin
            raw = classify(above_hi[i], below_lo[i]);
            // a slow edge passing through mid-rail must not look like float
            if (raw != st.cand[i])
            begin
                next_st.cand[i] = raw;
                next_st.cnt[i]  = 3'h1;
            end
            else if (st.cnt[i] < SENSE_STABLE_CYCLES)
                next_st.cnt[i] = st.cnt[i] + 3'h1;
            else
                next_st.lvl[i] = st.cand[i];
        end
    end

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            st <= '{lvl: '{default: LVL_FLOAT}, cand: '{default: LVL_FLOAT}, cnt: '0};
        else
            st <= next_st;
    end

    assign levels.lvl = st.lvl;

    a_level_settled: assert property (@(posedge clk) disable iff (!nrst)
        $changed(st.lvl[PIN_MODE]) |-> $past(st.cnt[PIN_MODE]) == SENSE_STABLE_CYCLES)
        else $error("mode pin level accepted before it was stable");

endmodule

// *** hw/control_mode_pin_decoder.sv ***
// control-mode pin decoder with ahb-lite status and control registers
//
// Design decisions made here: the AHB-Lite register port and the register addresses.
`timescale 1ns/1ns
module control_mode_pin_decoder
    import ctrl_pin_pkg::*;
(
    // clock and reset
    input  wire logic                 I_CLK,
    input  wire logic                 I_NRST,
    // ahb-lite slave
    input  wire logic                 I_HSEL,
    input  wire logic [31:0]          I_HADDR,
    input  wire logic [1:0]           I_HTRANS,
    input  wire logic                 I_HWRITE,
    input  wire logic [2:0]           I_HSIZE,
    input  wire logic [31:0]          I_HWDATA,
    input  wire logic                 I_HREADY,
    output logic                      O_HREADYOUT,
    output logic                      O_HRESP,
    output logic [31:0]               O_HRDATA,
    // configuration pin comparators
    input  wire logic [PIN_COUNT-1:0] I_PIN_ABOVE_HI,
    input  wire logic [PIN_COUNT-1:0] I_PIN_BELOW_LO,
    // decoded configuration
    output logic                      O_ANALOG_POWER_DOWN,
    output logic                      O_SERIAL_MODE,
    output logic                      O_FSR_HIGH,
    output logic                      O_OUTPUT_LEVEL_HIGH,
    output logic                      O_OUTPUT_EDGE_SELECT,
    output logic                      O_DDR_MODE,
    output logic                      O_CAL_DELAY_LONG,
    // output data clocking
    output logic                      O_DATA_OUTPUT_CLOCK,
    output logic                      O_WORD_LAUNCH
);

    typedef struct packed
    {
        rst_state_t  rst_st;
        logic [4:0]  rst_cnt;
        logic        analog_pd;
        logic        serial_mode;
        logic        fsr_high;
        logic        output_level_select_high;
        logic        edge_rise;
        logic        ddr;
        logic        cal_long;
        logic        ser_en;
        logic        data_output_clock_en;
        logic        div;
        logic        data_output_clock;
        logic        launch;
        logic        sclk_q;
        logic        cs_q;
        logic [31:0] shreg;
        logic [31:0] sword;
        logic [15:0] scount;
        logic        wr_pend;
        logic [3:0]  wr_addr;
        logic [31:0] hrdata;
    } dec_state_t;

    dec_state_t st;
    dec_state_t next_st;

    pin_levels_if levels ();

    tri_level_sense u_sense
    (
        .clk      (I_CLK),
        .nrst     (I_NRST),
        .above_hi (I_PIN_ABOVE_HI),
        .below_lo (I_PIN_BELOW_LO),
        .levels   (levels.sense)
    );

    // register read decode, used at the address phase
    function automatic logic [31:0] read_reg(input dec_state_t s, input logic [3:0] ofs,
                                             input level_t [PIN_COUNT-1:0] lv);
        logic [31:0] d;
        d = 32'h0;
        unique case (ofs)
            OFS_STATUS:
            begin
                d[ST_RUN]      = (s.rst_st == RST_RUN);
                d[ST_SERIAL]   = s.serial_mode;
                d[ST_FSR]      = s.fsr_high;
                d[ST_OUTPUT_LEVEL_SELECT]     = s.output_level_select_high;
                d[ST_EDGE]     = s.edge_rise;
                d[ST_DDR]      = s.ddr;
                d[ST_CAL_LONG] = s.cal_long;
                d[ST_SER_EN]   = s.ser_en;
                d[ST_LVL_LSB +: 2*PIN_COUNT] = lv;
            end
            OFS_CTRL:   d[CTRL_DATA_OUTPUT_CLOCK_EN] = s.data_output_clock_en;
            OFS_SWORD:  d = s.sword;
            OFS_SCOUNT: d[15:0] = s.scount;
            default:    d = 32'h0;
        endcase
        return d;
    endfunction

    logic addr_take;
    assign addr_take = I_HSEL && I_HTRANS[1] && I_HREADY;

    always_comb
    begin
        logic   run;
        logic   pin_mode;
        logic   sclk;
        logic   serial_data_pin;
        logic   cs_n;
        level_t mode_lvl;
        run      = (st.rst_st == RST_RUN);
        mode_lvl = levels.lvl[PIN_MODE];
        pin_mode = 1'b0;
        sclk     = I_PIN_ABOVE_HI[PIN_OUTPUT_LEVEL_SELECT];
        serial_data_pin    = I_PIN_ABOVE_HI[PIN_EDGE];
        cs_n     = I_PIN_ABOVE_HI[PIN_CAL];
        next_st  = st;

        // clocked internal reset; nothing is decoded until the clock has run this long
        unique case (st.rst_st)
            RST_HOLD:
            begin
                next_st.rst_st  = RST_COUNT;
                next_st.rst_cnt = 5'h0;
            end
            RST_COUNT:
            begin
                next_st.rst_cnt = st.rst_cnt + 5'h1;
                if (st.rst_cnt == RST_HOLD_CYCLES - 5'h1)
                begin
                    next_st.rst_st    = RST_RUN;
                    next_st.analog_pd = 1'b0;
                end
            end
            RST_RUN: ;
        endcase

        if (run)
        begin
            pin_mode            = (mode_lvl != LVL_FLOAT);
            next_st.serial_mode = !pin_mode;
            next_st.ser_en      = (levels.lvl[PIN_CAL] == LVL_FLOAT);
            if (pin_mode)
            begin
                next_st.fsr_high  = (mode_lvl == LVL_HIGH);
                next_st.output_level_select_high = (levels.lvl[PIN_OUTPUT_LEVEL_SELECT] == LVL_HIGH);
                next_st.ddr       = (levels.lvl[PIN_EDGE] == LVL_FLOAT);
                next_st.edge_rise = (levels.lvl[PIN_EDGE] == LVL_HIGH);
                next_st.cal_long  = (levels.lvl[PIN_CAL] == LVL_HIGH);
            end
            else
            begin
                // pin-set swing, range and edge hold; the serial word does not drive them
                next_st.cal_long = 1'b0;
            end
        end

        // serial capture: shift on serial clock rise while chip select is low
        next_st.sclk_q = sclk;
        next_st.cs_q   = cs_n;
        if (run && st.serial_mode)
        begin
            if (!cs_n && sclk && !st.sclk_q)
                next_st.shreg = {st.shreg[30:0], serial_data_pin};
            if (cs_n && !st.cs_q)
            begin
                next_st.sword  = st.shreg;
                next_st.scount = st.scount + 16'h1;
            end
        end

        // output data clock: half input rate single edge, quarter rate double edge
        next_st.launch = 1'b0;
        if (run && st.data_output_clock_en)
        begin
            // entering double rate, wait one cycle so the first half period is two cycles
            next_st.div = st.ddr ? !st.div : 1'b0;
            if (!st.ddr || st.div)
            begin
                next_st.data_output_clock   = !st.data_output_clock;
                // judged against the mode that stands with this clock level
                next_st.launch = next_st.ddr || (!st.data_output_clock == next_st.edge_rise);
            end
        end

        // ahb-lite: data registered at the address phase, so no wait states
        next_st.wr_pend = addr_take && I_HWRITE;
        if (addr_take)
            next_st.wr_addr = I_HADDR[3:0];
        if (addr_take && !I_HWRITE)
            next_st.hrdata = read_reg(st, I_HADDR[3:0], levels.lvl);
        if (st.wr_pend && st.wr_addr == OFS_CTRL)
            next_st.data_output_clock_en = I_HWDATA[CTRL_DATA_OUTPUT_CLOCK_EN];
    end

    always_ff @(posedge I_CLK or negedge I_NRST)
    begin
        if (!I_NRST)
        begin
            st           <= '0;
            st.rst_st    <= RST_HOLD;
            st.analog_pd <= 1'b1;
            st.data_output_clock_en   <= CTRL_DATA_OUTPUT_CLOCK_EN_RST;
            st.sclk_q    <= 1'b1;
            st.cs_q      <= 1'b1;
        end
        else
            st <= next_st;
    end

    assign O_HREADYOUT          = 1'b1;
    assign O_HRESP              = 1'b0;
    assign O_HRDATA             = st.hrdata;
    assign O_ANALOG_POWER_DOWN  = st.analog_pd;
    assign O_SERIAL_MODE        = st.serial_mode;
    assign O_FSR_HIGH           = st.fsr_high;
    assign O_OUTPUT_LEVEL_HIGH  = st.output_level_select_high;
    assign O_OUTPUT_EDGE_SELECT = st.edge_rise;
    assign O_DDR_MODE           = st.ddr;
    assign O_CAL_DELAY_LONG     = st.cal_long;
    assign O_DATA_OUTPUT_CLOCK  = st.data_output_clock;
    assign O_WORD_LAUNCH        = st.launch;

    default clocking cb @(posedge I_CLK); endclocking
    default disable iff (!I_NRST);

    a_reset_power_down: assert property (
        st.rst_st != RST_RUN |-> O_ANALOG_POWER_DOWN && !O_DATA_OUTPUT_CLOCK)
        else $error("analog powered up or clock running before internal reset ended");

    a_mode_to_pin: assert property (
        st.rst_st == RST_RUN && levels.lvl[PIN_MODE] != LVL_FLOAT |=> !O_SERIAL_MODE)
        else $error("driven mode pin did not select pin control");

    a_fsr_select: assert property (
        st.rst_st == RST_RUN && levels.lvl[PIN_MODE] == LVL_HIGH |=> O_FSR_HIGH ##0 !O_SERIAL_MODE)
        else $error("high mode pin did not select the large range");

    a_serial_select: assert property (
        st.rst_st == RST_RUN && levels.lvl[PIN_MODE] == LVL_FLOAT |=> O_SERIAL_MODE)
        else $error("floating mode pin did not select serial mode");

    a_output_level_select_follow: assert property (
        st.rst_st == RST_RUN && levels.lvl[PIN_MODE] != LVL_FLOAT
        |=> O_OUTPUT_LEVEL_HIGH == ($past(levels.lvl[PIN_OUTPUT_LEVEL_SELECT]) == LVL_HIGH))
        else $error("output swing does not follow its pin");

    a_serial_idle: assert property (
        !O_SERIAL_MODE && !$past(O_SERIAL_MODE) |=> $stable(st.scount))
        else $error("serial capture active in pin-controlled mode");

    a_edge_launch: assert property (
        O_WORD_LAUNCH && !O_DDR_MODE |-> O_DATA_OUTPUT_CLOCK == O_OUTPUT_EDGE_SELECT)
        else $error("single-rate word launched on the wrong edge");

    a_ddr_quarter: assert property (
        O_DDR_MODE && st.data_output_clock_en && $changed(O_DATA_OUTPUT_CLOCK)
        |=> !$changed(O_DATA_OUTPUT_CLOCK) ##1 (!O_DDR_MODE || !st.data_output_clock_en
            || $changed(O_DATA_OUTPUT_CLOCK)))
        else $error("double-rate output clock not at a quarter rate");

    a_ddr_both_edges: assert property (
        O_DDR_MODE && $past(O_DDR_MODE) && $changed(O_DATA_OUTPUT_CLOCK) |-> O_WORD_LAUNCH)
        else $error("double-rate edge without a word launch");

    a_cal_short: assert property (
        O_SERIAL_MODE |-> !O_CAL_DELAY_LONG)
        else $error("long calibration delay in serial mode");

    a_cal_select: assert property (
        st.rst_st == RST_RUN && levels.lvl[PIN_MODE] != LVL_FLOAT
        |=> O_CAL_DELAY_LONG == ($past(levels.lvl[PIN_CAL]) == LVL_HIGH))
        else $error("calibration delay does not follow its pin");

    a_cal_float: assert property (
        st.rst_st == RST_RUN && levels.lvl[PIN_CAL] == LVL_FLOAT |=> !O_CAL_DELAY_LONG)
        else $error("floating delay pin selected the long delay");

endmodule

// *** test/pin_host_model.sv ***
// host and board strapping model that drives the configuration pin comparators
`timescale 1ns/1ns
module pin_host_model
    import ctrl_pin_pkg::*;
(
    // clock
    input  wire logic                 clk,
    // comparator view of the pins
    output logic [PIN_COUNT-1:0]      above_hi,
    output logic [PIN_COUNT-1:0]      below_lo
);
    level_t [PIN_COUNT-1:0] lvl;

    initial
    begin
        for (int i = 0; i < PIN_COUNT; i++)
            lvl[i] = LVL_LOW;
    end

    // a floating pin rests between the thresholds, so neither comparator trips
    always_comb
    begin
        for (int i = 0; i < PIN_COUNT; i++)
        begin
            above_hi[i] = (lvl[i] == LVL_HIGH);
            below_lo[i] = (lvl[i] == LVL_LOW);
        end
    end

    task automatic put(input int p, input level_t v, input int hold);
        @(posedge clk);
        lvl[p] <= v;
        repeat (hold - 1) @(posedge clk);
    endtask

    task automatic set_all(input level_t [PIN_COUNT-1:0] v);
        @(posedge clk);
        lvl <= v;
    endtask

    // msb first; each clock half is long enough to pass the pin filter
    task automatic send_word(input logic [31:0] w);
        put(PIN_CAL, LVL_LOW, 8);
        for (int i = 31; i >= 0; i--)
        begin
            put(PIN_EDGE, w[i] ? LVL_HIGH : LVL_LOW, 8);
            put(PIN_OUTPUT_LEVEL_SELECT, LVL_HIGH, 8);
            put(PIN_OUTPUT_LEVEL_SELECT, LVL_LOW, 1);
        end
        put(PIN_CAL, LVL_HIGH, 8);
    endtask
endmodule

// *** test/control_mode_pin_decoder_test.sv ***
// self-checking bench for the control-mode pin decoder
`timescale 1ns/1ns
module control_mode_pin_decoder_test
    import ctrl_pin_pkg::*;
;
    logic                   clk;
    logic                   nrst;
    logic                   h_sel;
    logic [31:0]            h_addr;
    logic [1:0]             h_trans;
    logic                   h_write;
    logic [31:0]            h_wdata;
    wire logic              hready;
    wire logic              pd;
    wire logic              ser;
    wire logic              fsr;
    wire logic              output_level_select;
    wire logic              edge_sel;
    wire logic              ddr;
    wire logic              cal_long;
    wire logic              data_output_clock;
    wire logic              launch;
    wire logic [31:0]       hrdata;
    wire logic [PIN_COUNT-1:0] above_hi;
    wire logic [PIN_COUNT-1:0] below_lo;
    int                     errors = 0;
    int                     num_checks = 0;
    logic [31:0]            rd;

    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    initial
    begin
        nrst = 1'b0;
        h_sel = 1'b0;
        h_addr = 32'h0;
        h_trans = 2'h0;
        h_write = 1'b0;
        h_wdata = 32'h0;
    end

    pin_host_model i_host (.clk(clk), .above_hi(above_hi), .below_lo(below_lo));

    control_mode_pin_decoder i_dut (
        .I_CLK(clk), .I_NRST(nrst), .I_HSEL(h_sel), .I_HADDR(h_addr), .I_HTRANS(h_trans),
        .I_HWRITE(h_write), .I_HSIZE(3'h2), .I_HWDATA(h_wdata), .I_HREADY(hready),
        .O_HREADYOUT(hready), .O_HRESP(), .O_HRDATA(hrdata),
        .I_PIN_ABOVE_HI(above_hi), .I_PIN_BELOW_LO(below_lo),
        .O_ANALOG_POWER_DOWN(pd), .O_SERIAL_MODE(ser), .O_FSR_HIGH(fsr),
        .O_OUTPUT_LEVEL_HIGH(output_level_select), .O_OUTPUT_EDGE_SELECT(edge_sel), .O_DDR_MODE(ddr),
        .O_CAL_DELAY_LONG(cal_long), .O_DATA_OUTPUT_CLOCK(data_output_clock), .O_WORD_LAUNCH(launch));

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp)
        begin
            errors++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] wd);
        @(posedge clk);
        h_sel <= 1'b1;
        h_trans <= 2'h2;
        h_addr <= a;
        h_write <= wr;
        do @(posedge clk); while (hready !== 1'b1);
        h_sel <= 1'b0;
        h_trans <= 2'h0;
        h_wdata <= wd;
        do @(posedge clk); while (hready !== 1'b1);
        rd = hrdata;
    endtask

    task automatic pins(input level_t m, input level_t o, input level_t e, input level_t c);
        level_t [PIN_COUNT-1:0] p;
        p[PIN_MODE] = m;
        p[PIN_OUTPUT_LEVEL_SELECT] = o;
        p[PIN_EDGE] = e;
        p[PIN_CAL] = c;
        i_host.set_all(p);
        repeat (10) @(posedge clk);
        #1;
    endtask

    task automatic t_reset;
        repeat (11) @(posedge clk);
        #1;
        chk("power_down", 32'h1, pd);
        chk("serial", 32'h0, ser);
        @(posedge clk);
        nrst <= 1'b1;
        repeat (10) @(posedge clk);
        #1;
        chk("power_down", 32'h1, pd);
        repeat (15) @(posedge clk);
        #1;
        chk("power_down", 32'h0, pd);
        bus(1'b0, 32'(OFS_CTRL), 32'h0);
        chk("ctrl", 32'h1, rd);
        // status is read-only, so the write must leave it alone
        bus(1'b1, 32'(OFS_STATUS), 32'hffffffff);
        bus(1'b0, 32'(OFS_STATUS), 32'h0);
        chk("status", 32'h1, rd);
        $display("reset test done");
    endtask

    task automatic t_table;
        level_t      lv[3] = '{LVL_LOW, LVL_FLOAT, LVL_HIGH};
        logic [31:0] exp;
        logic [31:0] m;
        for (int mi = 0; mi < 2; mi++)
            for (int oi = 0; oi < 2; oi++)
                for (int ei = 0; ei < 3; ei++)
                    for (int ci = 0; ci < 3; ci++)
                    begin
                        pins(lv[2*mi], lv[2*oi], lv[ei], lv[ci]);
                        chk("serial", 32'h0, ser);
                        chk("fsr", 32'(mi), fsr);
                        chk("output_level_select", 32'(oi), output_level_select);
                        chk("ddr", 32'(ei == 1), ddr);
                        if (ei != 1)
                            chk("edge", 32'(ei == 2), edge_sel);
                        chk("cal_long", 32'(ci == 2), cal_long);
                        exp = 32'h0;
                        exp[15:8] = {lv[ci], lv[2*mi], lv[ei], lv[2*oi]};
                        exp[7:0] = {ci == 1, ci == 2, ei == 1, ei == 2, oi[0], mi[0], 2'b01};
                        m = (ei == 1) ? 32'hffffffef : 32'hffffffff;
                        bus(1'b0, 32'(OFS_STATUS), 32'h0);
                        chk("status", exp & m, rd & m);
                    end
        $display("pin table test done");
    endtask

    task automatic count_clk(input logic [31:0] tg_exp, input logic [31:0] ln_exp);
        int   tg;
        int   ln;
        logic prev;
        tg = 0;
        ln = 0;
        #1;
        prev = data_output_clock;
        repeat (32)
        begin
            @(posedge clk);
            #1;
            if (data_output_clock !== prev)
                tg++;
            if (launch === 1'b1)
                ln++;
            prev = data_output_clock;
        end
        chk("data_output_clock_toggles", tg_exp, 32'(tg));
        chk("launches", ln_exp, 32'(ln));
    endtask

    task automatic t_clock;
        pins(LVL_HIGH, LVL_HIGH, LVL_HIGH, LVL_LOW);
        count_clk(32'd32, 32'd16);
        pins(LVL_HIGH, LVL_HIGH, LVL_FLOAT, LVL_LOW);
        count_clk(32'd16, 32'd16);
        // disabling the data clock stops it even in double data rate
        bus(1'b1, 32'(OFS_CTRL), 32'h0);
        count_clk(32'd0, 32'd0);
        bus(1'b1, 32'(OFS_CTRL), 32'h1);
        $display("data clock test done");
    endtask

    task automatic t_serial;
        pins(LVL_LOW, LVL_LOW, LVL_LOW, LVL_FLOAT);
        i_host.send_word(32'h5a0fc3e1);
        bus(1'b0, 32'(OFS_SCOUNT), 32'h0);
        chk("count_pin_mode", 32'h0, rd);
        pins(LVL_FLOAT, LVL_LOW, LVL_LOW, LVL_HIGH);
        chk("serial", 32'h1, ser);
        chk("cal_long", 32'h0, cal_long);
        i_host.send_word(32'ha5c31e69);
        bus(1'b0, 32'(OFS_SWORD), 32'h0);
        chk("serial_word", 32'ha5c31e69, rd);
        bus(1'b0, 32'(OFS_SCOUNT), 32'h0);
        chk("serial_count", 32'h1, rd);
        $display("serial test done");
    endtask

    task automatic wrap_up;
        $display("checks %0d errors %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    initial
    begin
        t_reset;
        t_table;
        t_clock;
        t_serial;
        wrap_up;
    end

    // the whole run needs about 1800 cycles
    initial
    begin
        #100000;
        errors++;
        wrap_up;
    end
endmodule
